// file: hw/fsps_latch_if.sv
// signal bundle between the sequencer and its write latch memory
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
interface fsps_latch_if;
    logic                                wr_en;
    logic [fsps_pkg::LATCH_IDX_W-1:0]    wr_idx;
    logic [fsps_pkg::WORD_W-1:0]         wr_data;
    logic [fsps_pkg::LATCH_IDX_W-1:0]    rd_idx;
    logic [fsps_pkg::WORD_W-1:0]         rd_data;
    logic                                fill;

    modport ctrl (output wr_en, output wr_idx, output wr_data,
                  output rd_idx, output fill, input rd_data);
    modport mem  (input wr_en, input wr_idx, input wr_data,
                  input rd_idx, input fill, output rd_data);
endinterface

// file: hw/fsps_latch_mem.sv
// write latch block: one word per latch, registered read port
// assumes clk_in/rst_in of the sequencer; fill has priority over write
`timescale 1ns/1ps
module fsps_latch_mem
(
    // clock and reset
    input  wire logic    clk_in,
    input  wire logic    rst_in,
    // latch access
    fsps_latch_if.mem    lat
);

    logic [fsps_pkg::WORD_W-1:0] mem_q [fsps_pkg::LATCH_WORDS];
    logic [fsps_pkg::WORD_W-1:0] mem_d [fsps_pkg::LATCH_WORDS];
    logic [fsps_pkg::WORD_W-1:0] rd_q;
    logic [fsps_pkg::WORD_W-1:0] rd_d;

    ////////////////////////////////////////////////////////////////////
    // next contents: blank fill after a block program, else one write
    always_comb
    begin
        for (int i = 0; i < fsps_pkg::LATCH_WORDS; i++)
        begin
            if (lat.fill)
                mem_d[i] = fsps_pkg::LATCH_BLANK;
            else if (lat.wr_en && (lat.wr_idx == i[fsps_pkg::LATCH_IDX_W-1:0]))
                mem_d[i] = lat.wr_data;
            else
                mem_d[i] = mem_q[i];
        end
        rd_d = mem_q[lat.rd_idx];
    end

    // latches power up blank so untouched words program as erased
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            for (int i = 0; i < fsps_pkg::LATCH_WORDS; i++)
                mem_q[i] <= fsps_pkg::LATCH_BLANK;
            rd_q <= '0;
        end
        else
        begin
            for (int i = 0; i < fsps_pkg::LATCH_WORDS; i++)
                mem_q[i] <= mem_d[i];
            rd_q <= rd_d;
        end
    end

    assign lat.rd_data = rd_q;

endmodule // fsps_latch_mem

// file: hw/fsps_pkg.sv
// constants shared by the flash self-program sequencer files
// assumes a single 250 MHz system clock and an 8-bit register port
package fsps_pkg;

    // register indices on the 3-bit register port
    localparam logic [2:0] REG_CONTROL   = 3'h0;
    localparam logic [2:0] REG_UNLOCK    = 3'h1;
    localparam logic [2:0] REG_ADDR_LOW  = 3'h2;
    localparam logic [2:0] REG_ADDR_HIGH = 3'h3;
    localparam logic [2:0] REG_DATA_LOW  = 3'h4;
    localparam logic [2:0] REG_DATA_HIGH = 3'h5;

    // control register bit positions
    localparam int BIT_WRITE_START   = 0;
    localparam int BIT_WRITE_ENABLE  = 2;
    localparam int BIT_ROW_ERASE     = 4;
    localparam int BIT_LATCH_ONLY    = 5;
    localparam int BIT_CONFIG_SPACE  = 6;
    localparam int BIT_PROGRAM_SPACE = 7;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // unlock key bytes, in the order they must arrive
    localparam logic [7:0] UNLOCK_KEY_FIRST  = 8'h55;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;

    // array geometry
    localparam int ADDR_W      = 15;
    localparam int WORD_W      = 14;
    localparam int LATCH_WORDS = 8;
    localparam int LATCH_IDX_W = 3;
    localparam logic [WORD_W-1:0] LATCH_BLANK = 14'h3FFF;

    // timing: figures in their own units, counts derived from the clock
    localparam int CLK_MHZ        = 250;
    localparam int SETUP_CYCLES   = 2;
    localparam int ERASE_TIME_US  = 2000;
    localparam int PROG_TIME_US   = 2000;
    localparam int ERASE_CYCLES   = ERASE_TIME_US * CLK_MHZ;
    localparam int PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;
    localparam int TIMER_W        = 24;

    // sequencer states
    typedef enum logic [2:0] {
        SEQ_IDLE  = 3'b000,
        SEQ_SETUP = 3'b001,
        SEQ_LOAD  = 3'b010,
        SEQ_ERASE = 3'b011,
        SEQ_PROG  = 3'b100,
        SEQ_WAIT  = 3'b101,
        SEQ_DONE  = 3'b110
    } fsps_state_type;

    // unlock tracker states
    typedef enum logic [1:0] {
        UNL_NONE  = 2'b00,
        UNL_FIRST = 2'b01,
        UNL_ARMED = 2'b10
    } fsps_unlock_type;

endpackage

// file: hw/fsps_sequencer.sv
// flash self-program sequencer: registers, unlock check, erase/program
// assumes a processor register port and a flash array that takes one
// erase pulse or a stream of words and needs no handshake back
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module fsps_sequencer
#(
    parameter int ERASE_CYCLES = fsps_pkg::ERASE_CYCLES,
    parameter int PROG_CYCLES  = fsps_pkg::PROG_CYCLES
)
(
    // clock and reset
    input  wire logic                          clk_in,
    input  wire logic                          rst_in,
    // register port
    input  wire logic [2:0]                    reg_addr_in,
    input  wire logic [7:0]                    reg_wdata_in,
    input  wire logic                          reg_wr_in,
    input  wire logic                          reg_rd_in,
    output logic      [7:0]                    reg_rdata_out,
    // processor
    output logic                               cpu_stall_out,
    // flash array
    output logic                               flash_erase_out,
    output logic      [fsps_pkg::ADDR_W-1:0]   flash_row_addr_out,
    output logic                               flash_word_valid_out,
    output logic      [fsps_pkg::ADDR_W-1:0]   flash_word_addr_out,
    output logic      [fsps_pkg::WORD_W-1:0]   flash_word_data_out
);

    localparam int IW = fsps_pkg::LATCH_IDX_W;
    localparam int TW = fsps_pkg::TIMER_W;

    // latch slot of an address: the low bits inside the aligned block
    function automatic logic [IW-1:0] latch_slot(input logic [7:0] lo);
        latch_slot = lo[IW-1:0];
    endfunction

    // block base: address with the slot bits cleared
    function automatic logic [fsps_pkg::ADDR_W-1:0] block_base
        (input logic [6:0] hi, input logic [7:0] lo);
        block_base = {hi, lo[7:IW], {IW{1'b0}}};
    endfunction

    fsps_latch_if lat ();

    fsps_latch_mem u_latch_mem
    (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .lat    (lat)
    );

    ////////////////////////////////////////////////////////////////////
    // state
    fsps_pkg::fsps_state_type  state_q,   state_d;
    fsps_pkg::fsps_unlock_type unlock_q,  unlock_d;
    logic [7:0]                control_q, control_d;
    logic [7:0]                addr_lo_q, addr_lo_d;
    logic [6:0]                addr_hi_q, addr_hi_d;
    logic [7:0]                data_lo_q, data_lo_d;
    logic [5:0]                data_hi_q, data_hi_d;
    logic [TW-1:0]             timer_q,   timer_d;
    logic [IW:0]               word_q,    word_d;
    logic [7:0]                rdata_q,   rdata_d;
    logic                      erase_q,   erase_d;
    logic                      wvalid_q,  wvalid_d;
    logic [fsps_pkg::ADDR_W-1:0] waddr_q, waddr_d;
    logic [fsps_pkg::ADDR_W-1:0] row_q,   row_d;

    logic idle;
    logic ctrl_wr;
    logic start_ok;

    assign idle    = (state_q == fsps_pkg::SEQ_IDLE);
    assign ctrl_wr = reg_wr_in && (reg_addr_in == fsps_pkg::REG_CONTROL);

    // start needs the armed unlock, write enable, program space and
    // the write-start bit in the same control write
    assign start_ok = idle && ctrl_wr
        && (unlock_q == fsps_pkg::UNL_ARMED)
        && reg_wdata_in[fsps_pkg::BIT_WRITE_START]
        && reg_wdata_in[fsps_pkg::BIT_WRITE_ENABLE]
        && reg_wdata_in[fsps_pkg::BIT_PROGRAM_SPACE]
        && !reg_wdata_in[fsps_pkg::BIT_CONFIG_SPACE];

    ////////////////////////////////////////////////////////////////////
    // unlock tracker: any write other than the expected one disarms
    always_comb
    begin
        unlock_d = unlock_q;
        if (reg_wr_in && idle)
        begin
            if (reg_addr_in == fsps_pkg::REG_UNLOCK)
            begin
                if (reg_wdata_in == fsps_pkg::UNLOCK_KEY_FIRST)
                    unlock_d = fsps_pkg::UNL_FIRST;
                else if ((reg_wdata_in == fsps_pkg::UNLOCK_KEY_SECOND)
                         && (unlock_q == fsps_pkg::UNL_FIRST))
                    unlock_d = fsps_pkg::UNL_ARMED;
                else
                    unlock_d = fsps_pkg::UNL_NONE;
            end
            else
                unlock_d = fsps_pkg::UNL_NONE;   // one use, also on a start
        end
    end

    ////////////////////////////////////////////////////////////////////
    // software registers; writes are dropped while an operation runs
    always_comb
    begin
        control_d = control_q;
        addr_lo_d = addr_lo_q;
        addr_hi_d = addr_hi_q;
        data_lo_d = data_lo_q;
        data_hi_d = data_hi_q;
        if (reg_wr_in && idle)
        begin
            case (reg_addr_in)
                fsps_pkg::REG_CONTROL:
                begin
                    // write-start is never stored by software itself
                    control_d = reg_wdata_in;
                    control_d[fsps_pkg::BIT_WRITE_START] = start_ok;
                end
                fsps_pkg::REG_ADDR_LOW:  addr_lo_d = reg_wdata_in;
                fsps_pkg::REG_ADDR_HIGH: addr_hi_d = reg_wdata_in[6:0];
                fsps_pkg::REG_DATA_LOW:  data_lo_d = reg_wdata_in;
                fsps_pkg::REG_DATA_HIGH: data_hi_d = reg_wdata_in[5:0];
                default: ;
            endcase
        end
        if (state_q == fsps_pkg::SEQ_DONE)
        begin
            control_d[fsps_pkg::BIT_WRITE_START] = 1'b0;
            control_d[fsps_pkg::BIT_ROW_ERASE]   = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data, valid in the cycle after the read strobe only
    always_comb
    begin
        rdata_d = 8'h00;
        if (reg_rd_in)
        begin
            case (reg_addr_in)
                fsps_pkg::REG_CONTROL:   rdata_d = control_q;
                fsps_pkg::REG_ADDR_LOW:  rdata_d = addr_lo_q;
                fsps_pkg::REG_ADDR_HIGH: rdata_d = {1'b0, addr_hi_q};
                fsps_pkg::REG_DATA_LOW:  rdata_d = data_lo_q;
                fsps_pkg::REG_DATA_HIGH: rdata_d = {2'b00, data_hi_q};
                default:                 rdata_d = 8'h00;  // unlock reads 0
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // operation sequencer
    always_comb
    begin
        state_d   = state_q;
        timer_d   = timer_q;
        word_d    = word_q;
        erase_d   = 1'b0;
        wvalid_d  = 1'b0;
        waddr_d   = waddr_q;
        row_d     = row_q;
        lat.wr_en   = 1'b0;
        lat.wr_idx  = latch_slot(addr_lo_q);
        lat.wr_data = {data_hi_q, data_lo_q};
        lat.rd_idx  = word_q[IW-1:0];
        lat.fill    = 1'b0;
        case (state_q)
            fsps_pkg::SEQ_IDLE:
            begin
                timer_d = '0;
                if (start_ok)
                    state_d = fsps_pkg::SEQ_SETUP;
            end
            // two free cycles let the processor run its two no-ops
            fsps_pkg::SEQ_SETUP:
            begin
                timer_d = timer_q + 1'b1;
                if (timer_q == TW'(fsps_pkg::SETUP_CYCLES - 1))
                begin
                    timer_d = '0;
                    row_d   = block_base(addr_hi_q, addr_lo_q);
                    if (control_q[fsps_pkg::BIT_ROW_ERASE])
                    begin
                        state_d = fsps_pkg::SEQ_ERASE;
                        erase_d = 1'b1;
                    end
                    else
                        state_d = fsps_pkg::SEQ_LOAD;
                end
            end
            // erase never touches the latches
            fsps_pkg::SEQ_ERASE:
            begin
                timer_d = timer_q + 1'b1;
                if (timer_q == TW'(ERASE_CYCLES - 1))
                    state_d = fsps_pkg::SEQ_DONE;
            end
            fsps_pkg::SEQ_LOAD:
            begin
                lat.wr_en = 1'b1;
                word_d    = '0;
                if (control_q[fsps_pkg::BIT_LATCH_ONLY])
                    state_d = fsps_pkg::SEQ_DONE;
                else
                    state_d = fsps_pkg::SEQ_PROG;
            end
            // stream every latch, loaded or not, within the block
            fsps_pkg::SEQ_PROG:
            begin
                word_d   = word_q + 1'b1;
                wvalid_d = 1'b1;
                waddr_d  = row_q | {{(fsps_pkg::ADDR_W-IW){1'b0}},
                                    word_q[IW-1:0]};
                if (word_q == (IW+1)'(fsps_pkg::LATCH_WORDS - 1))
                begin
                    timer_d = '0;
                    state_d = fsps_pkg::SEQ_WAIT;
                end
            end
            fsps_pkg::SEQ_WAIT:
            begin
                timer_d = timer_q + 1'b1;
                if (timer_q == TW'(PROG_CYCLES - 1))
                begin
                    lat.fill = 1'b1;
                    state_d  = fsps_pkg::SEQ_DONE;
                end
            end
            fsps_pkg::SEQ_DONE:
                state_d = fsps_pkg::SEQ_IDLE;
            default:
                state_d = fsps_pkg::SEQ_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // all registers of the block
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_q   <= fsps_pkg::SEQ_IDLE;
            unlock_q  <= fsps_pkg::UNL_NONE;
            control_q <= fsps_pkg::CONTROL_RESET;
            addr_lo_q <= '0;
            addr_hi_q <= '0;
            data_lo_q <= '0;
            data_hi_q <= '0;
            timer_q   <= '0;
            word_q    <= '0;
            rdata_q   <= '0;
            erase_q   <= 1'b0;
            wvalid_q  <= 1'b0;
            waddr_q   <= '0;
            row_q     <= '0;
        end
        else
        begin
            state_q   <= state_d;
            unlock_q  <= unlock_d;
            control_q <= control_d;
            addr_lo_q <= addr_lo_d;
            addr_hi_q <= addr_hi_d;
            data_lo_q <= data_lo_d;
            data_hi_q <= data_hi_d;
            timer_q   <= timer_d;
            word_q    <= word_d;
            rdata_q   <= rdata_d;
            erase_q   <= erase_d;
            wvalid_q  <= wvalid_d;
            waddr_q   <= waddr_d;
            row_q     <= row_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs; stall drops one cycle after DONE so the third
    // instruction after the start is the next one fetched
    assign cpu_stall_out        = !idle && (state_q != fsps_pkg::SEQ_SETUP);
    assign reg_rdata_out        = rdata_q;
    assign flash_erase_out      = erase_q;
    assign flash_row_addr_out   = row_q;
    assign flash_word_valid_out = wvalid_q;
    assign flash_word_addr_out  = waddr_q;
    assign flash_word_data_out  = lat.rd_data;

endmodule // fsps_sequencer

// file: sim/fsps_flash_model.sv
// flash array stand-in: row erase, word program, overwrite counting
// assumes one-cycle erase pulses and one strobe per programmed word
`timescale 1ns/1ps
module fsps_flash_model
(
    // clock
    input  wire logic                        clk_in,
    // array side of the sequencer
    input  wire logic                        erase_in,
    input  wire logic [fsps_pkg::ADDR_W-1:0] row_addr_in,
    input  wire logic                        word_valid_in,
    input  wire logic [fsps_pkg::ADDR_W-1:0] word_addr_in,
    input  wire logic [fsps_pkg::WORD_W-1:0] word_data_in,
    // words programmed on top of unerased contents
    output int                               bad_writes_out = 0
);
    ////////////////////////////////////////////////////////////////
    logic [fsps_pkg::WORD_W-1:0] cells [int];

    // never-written cells count as blank; programming only clears bits
    always @(posedge clk_in)
    begin
        if (erase_in)
        begin
            for (int i = 0; i < fsps_pkg::LATCH_WORDS; i++)
                cells[int'(row_addr_in) + i] = fsps_pkg::LATCH_BLANK;
        end
        if (word_valid_in)
        begin
            if (cells.exists(int'(word_addr_in)))
            begin
                if (cells[int'(word_addr_in)] !== fsps_pkg::LATCH_BLANK
                    && word_data_in !== fsps_pkg::LATCH_BLANK)
                    bad_writes_out++;
                cells[int'(word_addr_in)] &= word_data_in;
            end
            else
                cells[int'(word_addr_in)] = word_data_in;
        end
    end
endmodule // fsps_flash_model

// file: sim/fsps_sequencer_properties.sv
// port assertions for the flash self-program sequencer, bound in below
// assumes software writes registers only while the sequencer is idle
`timescale 1ns/1ps
module fsps_sequencer_properties
#(
    parameter int ERASE_CYCLES = 20,
    parameter int PROG_CYCLES  = 10
)
(
    // clock and reset
    input wire logic        clk_in,
    input wire logic        rst_in,
    // register port
    input wire logic [2:0]  reg_addr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_rdata_out,
    // processor and flash
    input wire logic        cpu_stall_out,
    input wire logic        flash_erase_out,
    input wire logic [14:0] flash_row_addr_out,
    input wire logic        flash_word_valid_out,
    input wire logic [14:0] flash_word_addr_out
);
    ////////////////////////////////////////////////////////////////
    logic [1:0]  unl_q, unl_d;
    logic [23:0] run_q, run_d;
    logic        ers_q, ers_d;
    logic        ctl_wr, go;

    // unlock shadow; writes during an operation are dropped, so skipped
    assign ctl_wr = reg_wr_in && !cpu_stall_out && reg_addr_in == 3'h0;
    assign go = ctl_wr && unl_q == 2'h2 && reg_wdata_in[0]
                && reg_wdata_in[2] && reg_wdata_in[7] && !reg_wdata_in[6];

    // next unlock state, stall run length, erase seen in this run
    always_comb
    begin
        unl_d = unl_q;
        if (reg_wr_in && !cpu_stall_out)
        begin
            if (reg_addr_in != fsps_pkg::REG_UNLOCK)
                unl_d = 2'h0;
            else if (reg_wdata_in == fsps_pkg::UNLOCK_KEY_FIRST)
                unl_d = 2'h1;
            else if (reg_wdata_in == fsps_pkg::UNLOCK_KEY_SECOND
                     && unl_q == 2'h1)
                unl_d = 2'h2;
            else
                unl_d = 2'h0;
        end
        run_d = cpu_stall_out ? run_q + 24'h00_0001 : 24'h00_0000;
        // flag kept until the run ends so the fall still sees it
        ers_d = flash_erase_out | (ers_q & !(run_q != 0 && !cpu_stall_out));
    end

    // helper registers
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            unl_q <= 2'h0;
            run_q <= 24'h00_0000;
            ers_q <= 1'b0;
        end
        else
        begin
            unl_q <= unl_d;
            run_q <= run_d;
            ers_q <= ers_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    property p_ignored;
        ctl_wr && !go |=>
            (!cpu_stall_out && !flash_word_valid_out && !flash_erase_out)[*4];
    endproperty
    a_ignored: assert property (p_ignored)
        else $error("start without unlock was acted on");
    property p_setup;
        go |=> !cpu_stall_out[*2] ##1 cpu_stall_out;
    endproperty
    a_setup: assert property (p_setup)
        else $error("stall not after two setup cycles");
    property p_latch_only;
        go && reg_wdata_in[5] |=> !flash_word_valid_out[*8];
    endproperty
    a_latch_only: assert property (p_latch_only)
        else $error("latch load programmed flash");
    property p_erase_row;
        flash_erase_out |-> flash_row_addr_out[2:0] == 3'h0
            ##1 !flash_erase_out;
    endproperty
    a_erase_row: assert property (p_erase_row)
        else $error("erase pulse not a single aligned row");
    property p_erase_time;
        $fell(cpu_stall_out) && ers_q |->
            run_q >= ERASE_CYCLES && run_q <= ERASE_CYCLES + 2;
    endproperty
    a_erase_time: assert property (p_erase_time)
        else $error("erase stall length wrong");
    property p_burst;
        $rose(flash_word_valid_out) |->
            flash_word_valid_out[*8] ##1 !flash_word_valid_out;
    endproperty
    a_burst: assert property (p_burst)
        else $error("program burst not eight words");
    property p_first_aligned;
        $rose(flash_word_valid_out) |-> flash_word_addr_out[2:0] == 3'h0;
    endproperty
    a_first_aligned: assert property (p_first_aligned)
        else $error("program block not aligned");
    property p_addr_step;
        flash_word_valid_out && $past(flash_word_valid_out) |->
            flash_word_addr_out == $past(flash_word_addr_out) + 15'h0001;
    endproperty
    a_addr_step: assert property (p_addr_step)
        else $error("program word address not stepping by one");
    property p_word_stall;
        flash_word_valid_out |-> cpu_stall_out;
    endproperty
    a_word_stall: assert property (p_word_stall)
        else $error("words written while processor runs");
    property p_rdata_idle;
        !$past(reg_rd_in) |-> reg_rdata_out == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside its cycle");

    // main scenarios reached
    c_erase: cover property (go && reg_wdata_in[4]);
    c_load: cover property (go && reg_wdata_in[5]);
    c_prog: cover property ($rose(flash_word_valid_out));
endmodule // fsps_sequencer_properties

bind fsps_sequencer fsps_sequencer_properties
#(.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES))
i_fsps_sequencer_properties
(
    .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .cpu_stall_out(cpu_stall_out), .flash_erase_out(flash_erase_out),
    .flash_row_addr_out(flash_row_addr_out),
    .flash_word_valid_out(flash_word_valid_out),
    .flash_word_addr_out(flash_word_addr_out)
);

// file: sim/fsps_sequencer_tb.sv
// self-checking bench for the flash self-program sequencer
// assumes shortened erase/program counts and the flash model beside it
`timescale 1ns/1ps
module fsps_sequencer_tb;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [2:0]  reg_addr_in = 3'h0;
    logic [7:0]  reg_wdata_in = 8'h00;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic [7:0]  reg_rdata_out;
    logic        cpu_stall_out, flash_erase_out, flash_word_valid_out;
    logic [14:0] flash_row_addr_out, flash_word_addr_out;
    logic [13:0] flash_word_data_out;
    int          bad_writes;
    int          miscompares = 0;
    int          checked = 0;
    integer      seed = 33;
    logic        rd_pend = 1'b0;
    logic [7:0]  rd_q [$];
    logic [28:0] word_q [$];
    logic [14:0] erase_q [$];

    always #2 clk_in = ~clk_in;

    fsps_sequencer #(.ERASE_CYCLES(20), .PROG_CYCLES(10)) i_fsps_sequencer
    (
        .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .cpu_stall_out(cpu_stall_out), .flash_erase_out(flash_erase_out),
        .flash_row_addr_out(flash_row_addr_out),
        .flash_word_valid_out(flash_word_valid_out),
        .flash_word_addr_out(flash_word_addr_out),
        .flash_word_data_out(flash_word_data_out)
    );
    fsps_flash_model i_fsps_flash_model
    (
        .clk_in(clk_in), .erase_in(flash_erase_out),
        .row_addr_in(flash_row_addr_out),
        .word_valid_in(flash_word_valid_out),
        .word_addr_in(flash_word_addr_out),
        .word_data_in(flash_word_data_out), .bad_writes_out(bad_writes)
    );

    ////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (miscompares == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic compare(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one-cycle strobes with an idle cycle after each
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_wr_in    <= 1'b1;
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in    <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        rd_q.push_back(exp);
        @(posedge clk_in);
        reg_rd_in   <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in   <= 1'b0;
    endtask
    // register pair: low byte at a, high byte at a+1
    task automatic put(input logic [2:0] a, input logic [14:0] v);
        wr(a, v[7:0]);
        wr(a + 3'h1, 8'(v >> 8));
    endtask
    task automatic go(input logic [7:0] ctl);
        int n;
        wr(3'h1, fsps_pkg::UNLOCK_KEY_FIRST);
        wr(3'h1, fsps_pkg::UNLOCK_KEY_SECOND);
        wr(3'h0, ctl);
        repeat (4) @(posedge clk_in);
        for (n = 0; n < 100 && cpu_stall_out !== 1'b0; n++)
            @(posedge clk_in);
        compare("stall release", 1'b0, cpu_stall_out);
    endtask
    task automatic load(input logic [14:0] a, input logic [13:0] d,
                        input logic [7:0] ctl);
        put(3'h2, a);
        put(3'h4, {1'b0, d});
        go(ctl);
    endtask
    // latch-only loads of sel, then the final load programs the block
    task automatic burst(input logic [14:0] base, input logic [7:0] sel,
                         input int last);
        logic [13:0] img [8];
        for (int i = 0; i < 8; i++)
        begin
            img[i] = fsps_pkg::LATCH_BLANK;
            if (sel[i])
            begin
                img[i] = 14'($random(seed));
                load(base + 15'(i), img[i], 8'hA5);
            end
        end
        img[last] = 14'($random(seed));
        for (int i = 0; i < 8; i++)
            word_q.push_back({base + 15'(i), img[i]});
        load(base + 15'(last), img[last], 8'h85);
        rd(3'h0, 8'h84);
    endtask

    // output watcher: oldest note against each result
    always @(posedge clk_in)
    begin
        if (rd_pend)
            compare("read data", rd_q.pop_front(), reg_rdata_out);
        rd_pend <= reg_rd_in;
        if (flash_word_valid_out === 1'b1)
            compare("flash word", word_q.size() ? word_q.pop_front() : '1,
                    {flash_word_addr_out, flash_word_data_out});
        if (flash_erase_out === 1'b1)
            compare("erase row", erase_q.size() ? erase_q.pop_front() : '1,
                    flash_row_addr_out);
    end

    initial
    begin
        #(4 * 5000);
        miscompares++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(3'h0, fsps_pkg::CONTROL_RESET);
        rd(3'h1, 8'h00);
        rd(3'h6, 8'h00);
        put(3'h2, 15'h0123);
        put(3'h4, 15'h1234);
        wr(3'h0, 8'h85);
        rd(3'h0, 8'h84);
        wr(3'h1, 8'hAA);
        wr(3'h1, 8'h55);
        wr(3'h0, 8'h85);
        wr(3'h1, 8'h55);
        wr(3'h1, 8'hAA);
        wr(3'h2, 8'h23);
        wr(3'h0, 8'h85);
        go(8'h81);
        rd(3'h0, 8'h80);
        go(8'hC5);
        erase_q.push_back(15'h0120);
        go(8'h95);
        rd(3'h0, 8'h84);
        burst(15'h0120, 8'b0010_0101, 7);
        put(3'h2, 15'h0205);
        erase_q.push_back(15'h0200);
        go(8'h95);
        burst(15'h0200, 8'h00, 3);
        compare("overwrites", 0, bad_writes);
        compare("words left", 0, word_q.size() + erase_q.size());
        conclude();
    end
endmodule // fsps_sequencer_tb
